//--- common/igc_defs.svh
`ifndef IGC_DEFS_SVH
`define IGC_DEFS_SVH

// Register indices; byte address is four times the index
`define IGC_IDX_EDGE      8'hBF
`define IGC_IDX_STACK     8'hDF
`define IGC_IDX_ENABLE    8'hC9
`define IGC_IDX_REQUEST   8'hC8
`define IGC_IDX_EVSTAT    8'hF0
`define IGC_IDX_EVMASK    8'hF1

// Field positions
`define IGC_BIT_GIE       7
`define IGC_SP_HI         2
`define IGC_P0SEL_LO      3
`define IGC_P1SEL_LO      5
`define IGC_SRC_PIN0      0
`define IGC_SRC_PIN1      1
`define IGC_SRC_TX        2
`define IGC_SRC_RX        3
`define IGC_SRC_BTMR      4
`define IGC_SRC_TCNT      5
`define IGC_SRC_ADC       7

// Implemented source bits (bit 6 is reserved)
`define IGC_SRC_MASK      8'hBF

// Writable bits of the edge select register (both select fields)
`define IGC_EDGE_WMASK    8'h78

// Reset values
`define IGC_RST_EDGE      8'h50
`define IGC_RST_SP        3'h7
`define IGC_RST_GIE       1'b0

// Vector address loaded into the program counter
`define IGC_VEC_ADDR      12'h008

`endif

//--- common/igc_pkg.sv
package igc_pkg;

    typedef enum logic [1:0] {
        IGC_EDGE_NONE = 2'h0,
        IGC_EDGE_RISE = 2'h1,
        IGC_EDGE_FALL = 2'h2,
        IGC_EDGE_BOTH = 2'h3
    } igc_edge_t;

    // Single-cycle event pulses from on-chip peripherals
    typedef struct packed {
        logic adcDone;
        logic tmrCntOvf;
        logic baseTmrOvf;
        logic rxDone;
        logic txDone;
    } igc_evt_t;

    // Vector load presented to the program sequencer
    typedef struct packed {
        logic        load;
        logic [11:0] pc;
        logic [11:0] retAddr;
        logic [2:0]  slot;
    } igc_vec_t;

endpackage : igc_pkg

//--- rtl/igc_top.sv
`timescale 1ns/10ps
`include "igc_defs.svh"
// Behaviour
// - No vectoring while the global enable bit (stack register bit 7) is zero.
// - On acceptance load PC with 8 and push return address one stack level.
// - Stack register: 3-bit pointer resetting to ones, global enable resetting to 0.
// - Entry saves neither accumulator nor flag register; software does that.
// - Selected pin edge sets its request flag regardless of its enable bit.
// - Vector only for a source whose flag and enable are both set.
// - Pin 0 select bits 4:3: 01 rise, 10 fall, 11 both, 00 reserved.
// - Pin 1 select bits 6:5 same coding, resetting to falling edge.
// - Flags set by pin edges, both timer overflows, ADC end, serial tx/rx end.
// - Flags set by events whether enabled or not; a flag alone causes no vectoring.
// - Global enable cleared on service entry and set again on return.
// - Enable register: one read/write bit per source at fixed positions.
module igc_top #(
    parameter int ADDR_W = 10
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  wbCyc,
    input  wire logic                  wbStb,
    input  wire logic                  wbWe,
    input  wire logic [ADDR_W-1:0]     wbAdr,
    input  wire logic [3:0]            wbSel,
    input  wire logic [31:0]           wbDatW,
    output logic      [31:0]           wbDatR,
    output logic                       wbAck,
    input  wire logic                  extIrqPin0,
    input  wire logic                  extIrqPin1,
    input  wire igc_pkg::igc_evt_t     evt,
    input  wire logic                  coreReady,
    input  wire logic                  retiDone,
    input  wire logic [11:0]           curPc,
    output igc_pkg::igc_vec_t          vec,
    output logic                       irqOut
);
    import igc_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic edgeHit(input logic [1:0] sel, input logic cur,
                                     input logic prev);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = ~cur & prev;
        case (igc_edge_t'(sel))
            IGC_EDGE_RISE: edgeHit = rise;
            IGC_EDGE_FALL: edgeHit = fall;
            IGC_EDGE_BOTH: edgeHit = rise | fall;
            default:       edgeHit = 1'b0;
        endcase
    endfunction : edgeHit

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]  edgeSel_q;
    logic [7:0]  irqEn_q;
    logic [7:0]  irqReq_q;
    logic [7:0]  irqReq_d;
    logic [7:0]  evStat_q;
    logic [7:0]  evStat_d;
    logic [7:0]  evMask_q;
    logic        gie_q;
    logic        gie_d;
    logic [2:0]  stackPtr_q;
    logic [2:0]  stackPtr_d;
    logic [1:0]  pin0Sync_q;
    logic [1:0]  pin1Sync_q;
    logic        pin0Prev_q;
    logic        pin1Prev_q;
    logic        ack_q;
    logic [31:0] datR_q;
    igc_vec_t    vec_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire        busReq   = wbCyc & wbStb & ~ack_q;
    wire        busWr    = busReq & wbWe & wbSel[0];
    wire [7:0]  regIdx   = wbAdr[9:2];
    wire [7:0]  wrByte   = wbDatW[7:0];
    wire        wrEdge   = busWr & (regIdx == `IGC_IDX_EDGE);
    wire        wrStack  = busWr & (regIdx == `IGC_IDX_STACK);
    wire        wrEnable = busWr & (regIdx == `IGC_IDX_ENABLE);
    wire        wrReq    = busWr & (regIdx == `IGC_IDX_REQUEST);
    wire        wrStat   = busWr & (regIdx == `IGC_IDX_EVSTAT);
    wire        wrMask   = busWr & (regIdx == `IGC_IDX_EVMASK);
    wire [7:0]  stackRd  = {gie_q, 4'h0, stackPtr_q};
    wire [7:0]  rdByte   =
        (regIdx == `IGC_IDX_EDGE)    ? edgeSel_q :
        (regIdx == `IGC_IDX_STACK)   ? stackRd :
        (regIdx == `IGC_IDX_ENABLE)  ? irqEn_q :
        (regIdx == `IGC_IDX_REQUEST) ? irqReq_q :
        (regIdx == `IGC_IDX_EVSTAT)  ? evStat_q :
        (regIdx == `IGC_IDX_EVMASK)  ? evMask_q : 8'h00;

    // ------------------------------------------------------------
    // Pin synchronisers and edge detect
    // ------------------------------------------------------------
    wire [1:0] pin0Sel = edgeSel_q[`IGC_P0SEL_LO +: 2];
    wire [1:0] pin1Sel = edgeSel_q[`IGC_P1SEL_LO +: 2];
    wire       pin0Hit = edgeHit(pin0Sel, pin0Sync_q[1], pin0Prev_q);
    wire       pin1Hit = edgeHit(pin1Sel, pin1Sync_q[1], pin1Prev_q);

    always_ff @(posedge clk) begin
        if (rst) begin
            pin0Sync_q <= 2'h0;
            pin1Sync_q <= 2'h0;
            pin0Prev_q <= 1'b0;
            pin1Prev_q <= 1'b0;
        end else begin
            pin0Sync_q <= {pin0Sync_q[0], extIrqPin0};
            pin1Sync_q <= {pin1Sync_q[0], extIrqPin1};
            pin0Prev_q <= pin0Sync_q[1];
            pin1Prev_q <= pin1Sync_q[1];
        end
    end

    // ------------------------------------------------------------
    // Request flags
    // ------------------------------------------------------------
    wire [7:0] evtVec = {evt.adcDone, 1'b0, evt.tmrCntOvf, evt.baseTmrOvf,
                         evt.rxDone, evt.txDone, pin1Hit, pin0Hit};

    // Events override a same-cycle software write
    always_comb begin
        irqReq_d = irqReq_q;
        if (wrReq) begin
            irqReq_d = wrByte;
        end
        irqReq_d = (irqReq_d | evtVec) & `IGC_SRC_MASK;
    end

    // ------------------------------------------------------------
    // Vectoring and stack
    // ------------------------------------------------------------
    wire [7:0] pendEn = irqReq_q & irqEn_q & `IGC_SRC_MASK;
    wire       take   = gie_q & (|pendEn) & coreReady;

    // PC, return address, slot, stack pointer and global enable move; accumulator and flags are untouched
    always_comb begin
        gie_d      = gie_q;
        stackPtr_d = stackPtr_q;
        if (wrStack) begin
            gie_d      = wrByte[`IGC_BIT_GIE];
            stackPtr_d = wrByte[`IGC_SP_HI:0];
        end
        if (take) begin
            gie_d      = 1'b0;
            stackPtr_d = stackPtr_q - 3'h1;
        end else if (retiDone) begin
            gie_d      = 1'b1;
            stackPtr_d = stackPtr_q + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            vec_q <= '0;
        end else begin
            vec_q.load    <= take;
            vec_q.pc      <= take ? `IGC_VEC_ADDR : vec_q.pc;
            vec_q.retAddr <= take ? curPc : vec_q.retAddr;
            vec_q.slot    <= take ? stackPtr_q : vec_q.slot;
        end
    end

    // ------------------------------------------------------------
    // Event status and interrupt output
    // ------------------------------------------------------------
    always_comb begin
        evStat_d = evStat_q;
        if (wrStat) begin
            evStat_d = evStat_q & ~wrByte;
        end
        evStat_d = (evStat_d | evtVec) & `IGC_SRC_MASK;
    end

    assign irqOut = |(evStat_q & evMask_q);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            edgeSel_q  <= `IGC_RST_EDGE;
            irqEn_q    <= 8'h00;
            irqReq_q   <= 8'h00;
            evStat_q   <= 8'h00;
            evMask_q   <= 8'h00;
            gie_q      <= `IGC_RST_GIE;
            stackPtr_q <= `IGC_RST_SP;
        end else begin
            if (wrEdge) begin
                edgeSel_q <= wrByte & `IGC_EDGE_WMASK;
            end
            if (wrEnable) begin
                irqEn_q <= wrByte & `IGC_SRC_MASK;
            end
            if (wrMask) begin
                evMask_q <= wrByte & `IGC_SRC_MASK;
            end
            irqReq_q   <= irqReq_d;
            evStat_q   <= evStat_d;
            gie_q      <= gie_d;
            stackPtr_q <= stackPtr_d;
        end
    end

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_q  <= 1'b0;
            datR_q <= 32'h0000_0000;
        end else begin
            ack_q  <= busReq;
            datR_q <= busReq ? {24'h00_0000, rdByte} : datR_q;
        end
    end

    assign wbAck  = ack_q;
    assign wbDatR = datR_q;
    assign vec    = vec_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_no_take_gie: assert property (
        !gie_q |=> !vec_q.load)
        else $error("vector taken with global enable low");

    chk_vec_addr: assert property (
        vec_q.load |-> vec_q.pc == `IGC_VEC_ADDR && vec_q.slot == $past(stackPtr_q)
        && stackPtr_q == $past(stackPtr_q) - 3'h1)
        else $error("vector load without pc 8 and stack push");

    chk_gie_clear: assert property (
        vec_q.load |-> !gie_q)
        else $error("global enable still set after entry");

    chk_return_from_irq_gie: assert property (
        retiDone && !take |=> gie_q)
        else $error("return did not restore global enable");

    chk_flag_sticky: assert property (
        irqReq_q[0] && !wrReq |=> irqReq_q[0])
        else $error("request flag cleared by hardware");

    chk_evt_wins: assert property (
        evtVec != 8'h00 |=> (irqReq_q & $past(evtVec)) == $past(evtVec))
        else $error("event lost from request flags");

    chk_gate_enable: assert property (
        vec_q.load |-> $past(pendEn) != 8'h00)
        else $error("vector without enabled request");

    chk_pin_flag: assert property (
        pin0Hit |=> irqReq_q[0])
        else $error("pin 0 edge did not set flag");

    chk_reserved_sel: assert property (
        pin0Sel == 2'h0 |-> !pin0Hit)
        else $error("reserved select fired");

    chk_pending_take: assert property (
        gie_q && coreReady && (|pendEn) |=> vec_q.load)
        else $error("enabled request not vectored");

    chk_bus_ack: assert property (
        busReq |=> wbAck ##1 !wbAck)
        else $error("bus ack not a single cycle");

    chk_return_from_irq_ptr: assert property (
        retiDone && !take |=> stackPtr_q == $past(stackPtr_q) + 3'h1)
        else $error("return did not pop the stack pointer");

    chk_ret_addr: assert property (
        vec_q.load |-> vec_q.retAddr == $past(curPc))
        else $error("return address not the pc at acceptance");

    chk_vec_hold: assert property (
        !vec_q.load |-> $stable(vec_q.pc) && $stable(vec_q.retAddr) && $stable(vec_q.slot))
        else $error("vector fields changed without a load");

    chk_load_pulse: assert property (
        vec_q.load |=> !vec_q.load)
        else $error("nested vector load");

    chk_pin1_flag: assert property (
        pin1Hit |=> irqReq_q[1])
        else $error("pin 1 edge did not set flag");

    chk_reserved_sel1: assert property (
        pin1Sel == 2'h0 |-> !pin1Hit)
        else $error("reserved select fired on pin 1");

    chk_rise_sel: assert property (
        pin0Sel == 2'h1 |-> pin0Hit == (pin0Sync_q[1] && !pin0Prev_q))
        else $error("pin 0 rising select wrong");

    chk_fall_sel: assert property (
        pin0Sel == 2'h2 |-> pin0Hit == (!pin0Sync_q[1] && pin0Prev_q))
        else $error("pin 0 falling select wrong");

    chk_both_sel: assert property (
        pin0Sel == 2'h3 |-> pin0Hit == (pin0Sync_q[1] != pin0Prev_q))
        else $error("pin 0 both-edge select wrong");

    chk_pin1_rise: assert property (
        pin1Sel == 2'h1 |-> pin1Hit == (pin1Sync_q[1] && !pin1Prev_q))
        else $error("pin 1 rising select wrong");

    chk_pin1_fall: assert property (
        pin1Sel == 2'h2 |-> pin1Hit == (!pin1Sync_q[1] && pin1Prev_q))
        else $error("pin 1 falling select wrong");

    chk_enable_gate: assert property (
        irqEn_q == 8'h00 |=> !vec_q.load)
        else $error("vector with all enables clear");

    chk_req_write: assert property (
        wrReq && evtVec == 8'h00 |=> irqReq_q == ($past(wrByte) & `IGC_SRC_MASK))
        else $error("request flag write not applied");

    cov_take: cover property (vec_q.load);
    cov_return_from_irq: cover property (vec_q.load ##[1:50] retiDone);
    cov_both_edges: cover property (pin0Sel == 2'h3 && pin0Hit);
    cov_set_clear: cover property (wrReq && |(evtVec & ~wrByte));
    cov_pin1_fall: cover property (pin1Sel == 2'h2 && pin1Hit);

endmodule : igc_top

//--- tb/igc_core_model.sv
`timescale 1ns/10ps
module igc_core_model (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              slow,
    input  wire igc_pkg::igc_vec_t vec,
    output logic                   coreReady,
    output logic                   retiDone,
    output logic [11:0]            curPc
);
    import igc_pkg::*;
    int svcCnt;

    assign curPc = 12'h3A5;

    // Handler saves nothing itself, counts svcCnt down from 20 (slow) or 3, then returns
    always @(posedge clk) begin
        retiDone <= 1'b0;
        if (rst) begin
            svcCnt    <= 0;
            coreReady <= 1'b0;
        end else if (vec.load) begin
            svcCnt    <= slow ? 20 : 3;
            coreReady <= 1'b0;
        end else if (svcCnt > 1) begin
            svcCnt <= svcCnt - 1;
        end else if (svcCnt == 1) begin
            svcCnt    <= 0;
            retiDone  <= 1'b1;
            coreReady <= 1'b1;
        end else begin
            coreReady <= 1'b1;
        end
    end
endmodule : igc_core_model

//--- tb/testbench.sv
`timescale 1ns/10ps
`include "igc_defs.svh"
`define CHK(got, exp) \
    begin \
        checks++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module testbench;
    import igc_pkg::*;
    logic        clk, rst, wbCyc, wbStb, wbWe, wbAck, pin0, pin1;
    logic        coreReady, retiDone, irqOut, slow;
    logic [9:0]  wbAdr;
    logic [3:0]  wbSel;
    logic [31:0] wbDatW, wbDatR;
    logic [11:0] curPc;
    logic [7:0]  rdVal;
    igc_evt_t    evt;
    igc_vec_t    vec;
    int          num_errors, checks, loadCount, cycleCount, n;
    int          srcBit [5] = '{2, 3, 4, 5, 7};

    igc_top u_igc_top (.clk(clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
        .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
        .extIrqPin0(pin0), .extIrqPin1(pin1), .evt(evt), .coreReady(coreReady),
        .retiDone(retiDone), .curPc(curPc), .vec(vec), .irqOut(irqOut));
    igc_core_model u_igc_core_model (.clk(clk), .rst(rst), .slow(slow), .vec(vec),
        .coreReady(coreReady), .retiDone(retiDone), .curPc(curPc));

    // ----------------------------------------
    // Bus access and reporting
    // ----------------------------------------
    task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge clk);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= we;
        wbAdr  <= {idx, 2'b00};
        wbDatW <= {24'h0, wd};
        do @(posedge clk); while (wbAck !== 1'b1);
        rdVal = wbDatR[7:0];
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe  <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        wb(1'b1, idx, wd);
    endtask : wr

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00);
        `CHK(rdVal, exp)
    endtask : rdc

    task automatic pulse(input logic [4:0] bits);
        @(posedge clk);
        evt <= igc_evt_t'(bits);
        @(posedge clk);
        evt <= '0;
    endtask : pulse

    task automatic conclude;
        if (num_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        loadCount  <= loadCount + int'(vec.load);
        cycleCount <= cycleCount + 1;
        if (cycleCount == 3000) begin
            num_errors++;
            conclude();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst, slow, wbSel} = 6'h3F;
        {wbCyc, wbStb, wbWe, pin0, pin1, wbAdr, wbDatW} = '0;
        evt = '0;
        {num_errors, checks, loadCount, cycleCount} = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(`IGC_IDX_EDGE, 8'h50);
        rdc(`IGC_IDX_STACK, 8'h07);
        rdc(`IGC_IDX_ENABLE, 8'h00);
        wr(`IGC_IDX_ENABLE, 8'hFF);
        rdc(`IGC_IDX_ENABLE, 8'hBF);
        rdc(8'h10, 8'h00);
        wr(`IGC_IDX_STACK, 8'h05);
        rdc(`IGC_IDX_STACK, 8'h05);
        wr(`IGC_IDX_STACK, 8'h07);
        wr(`IGC_IDX_ENABLE, 8'h00);
        for (int i = 0; i < 5; i++) begin
            pulse(5'h01 << i);
            rdc(`IGC_IDX_REQUEST, 8'h01 << srcBit[i]);
            wr(`IGC_IDX_REQUEST, 8'h00);
        end
        rdc(`IGC_IDX_EVSTAT, 8'hBC);
        `CHK(irqOut, 1'b0)
        wr(`IGC_IDX_EVMASK, 8'h80);
        `CHK(irqOut, 1'b1)
        wr(`IGC_IDX_EVSTAT, 8'h80);
        `CHK(irqOut, 1'b0)
        rdc(`IGC_IDX_EVSTAT, 8'h3C);
        fork
            wr(`IGC_IDX_REQUEST, 8'h00);
            pulse(5'h01);
        join
        rdc(`IGC_IDX_REQUEST, 8'h04);
        for (int c = 0; c < 4; c++) begin
            wr(`IGC_IDX_EDGE, {1'b0, 2'(c), 2'(c), 3'b000});
            wr(`IGC_IDX_REQUEST, 8'h00);
            {pin0, pin1} <= 2'b11;
            repeat (6) @(posedge clk);
            rdc(`IGC_IDX_REQUEST, (c == 1 || c == 3) ? 8'h03 : 8'h00);
            wr(`IGC_IDX_REQUEST, 8'h00);
            {pin0, pin1} <= 2'b00;
            repeat (6) @(posedge clk);
            rdc(`IGC_IDX_REQUEST, (c >= 2) ? 8'h03 : 8'h00);
        end
        rdc(`IGC_IDX_EDGE, 8'h78);
        wr(`IGC_IDX_REQUEST, 8'h00);
        wr(`IGC_IDX_ENABLE, 8'h04);
        pulse(5'h01);
        repeat (5) @(posedge clk);
        `CHK(loadCount, 0)
        wr(`IGC_IDX_ENABLE, 8'h08);
        wr(`IGC_IDX_STACK, 8'h87);
        repeat (5) @(posedge clk);
        `CHK(loadCount, 0)
        pulse(5'h02);
        n = 0;
        while (loadCount == 0 && n < 10) begin
            @(posedge clk);
            n++;
        end
        `CHK(loadCount, 1)
        `CHK(vec.pc, `IGC_VEC_ADDR)
        `CHK(vec.retAddr, 12'h3A5)
        `CHK(vec.slot, 3'h7)
        rdc(`IGC_IDX_STACK, 8'h06);
        wr(`IGC_IDX_REQUEST, 8'h00);
        repeat (25) @(posedge clk);
        rdc(`IGC_IDX_STACK, 8'h87);
        `CHK(loadCount, 1)
        slow <= 1'b0;
        pulse(5'h02);
        n = 0;
        while (loadCount == 1 && n < 10) begin
            @(posedge clk);
            n++;
        end
        `CHK(loadCount, 2)
        `CHK(vec.slot, 3'h7)
        wr(`IGC_IDX_REQUEST, 8'h00);
        repeat (10) @(posedge clk);
        rdc(`IGC_IDX_STACK, 8'h87);
        `CHK(loadCount, 2)
        conclude();
    end
endmodule : testbench
